// >>> ubd_pkg.sv
// Summary of operation
// - non-extended mode: shared aux offset is a plain read/write scratch byte
// - extended mode: shared offset shows aux byte, meaning set by mode bits 7:5
// - aux status/control byte clears fully on hardware reset
// - tx soft reset clears aux bits 2,6; rx soft reset clears 0,1,4,5
// - aux bit 0 read-only timeout flag, set on timeout, cleared by rx read
// - offsets 0,1 shared by data ports and legacy divisor, chosen by bit 7
// - bank 1: divisor low 00h, high 01h, line control 03h, rest reserved
// - any legacy divisor access forces non-extended mode; lock only blocks fallback when already non-extended
// - non-extended and locked: legacy divisor access leaves divisor untouched
// - fallback from extended clears mode 2-7, ext1 0,5,7, ext2 0-5
// - non-extended unlocked fallback clears ext1 5,7, ext2 0-5; locked none
// - 24 MHz prescaled by 13, 1.625 or 1 then divided by divisor
// - sixteen-times tick drives serial logic; divide by 16 gives bit rate
// - divisor loaded by software; counter reloads one cycle after each byte write
// - bank 2 divisor ports reach same divisor, never trigger fallback
// - bank 2 divisor high write changes baud rate one cycle later
// - bank 2 map: div 00/01, ext1 02, lcr 03, ext2 04, levels 06/07
// - ext2 bits 5:4: 00 div 13, 01 div 1.625, 11 div 1, 10 reserved
// - locked non-extended: legacy divisor offsets hit two scratch bytes
// - ext1 bit 0 set selects extended mode
package ubd_pkg;

  // ---------------------------------------------------------------
  // host port
  // ---------------------------------------------------------------
  localparam int ADDR_W = 3;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } ubd_bus_req_t;

  // ---------------------------------------------------------------
  // offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_DIV_LO = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_DIV_HI = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_EXT1   = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_LCR    = 3'h3;
  localparam logic [ADDR_W-1:0] OFF_EXT2   = 3'h4;
  localparam logic [ADDR_W-1:0] OFF_MCR    = 3'h4;
  localparam logic [ADDR_W-1:0] OFF_TXLV   = 3'h6;
  localparam logic [ADDR_W-1:0] OFF_RXLV   = 3'h7;
  localparam logic [ADDR_W-1:0] OFF_AUX    = 3'h7;

  // ---------------------------------------------------------------
  // banks, decoded from the line control byte
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BANK0 = 2'b00,
    BANK1 = 2'b01,
    BANK2 = 2'b10,
    BANK3 = 2'b11
  } ubd_bank_t;

  localparam int         BANK_SELECT_ENABLE_BIT   = 7;
  localparam logic [7:0] BANK2_CODE = 8'he0;
  localparam logic [7:0] BANK3_CODE = 8'he4;

  // ---------------------------------------------------------------
  // fields and masks
  // ---------------------------------------------------------------
  localparam int         EXT_SEL_BIT  = 0;
  localparam int         LOCK_BIT     = 7;
  localparam int         PRESCALER_SELECT_LO     = 4;
  localparam int         MODE_LO      = 5;
  localparam int         RXTO_BIT     = 0;
  localparam logic [7:0] MCR_CLR_EXT  = 8'hfc;
  localparam logic [7:0] EXT1_CLR_EXT = 8'ha1;
  localparam logic [7:0] EXT1_CLR_NE  = 8'ha0;
  localparam logic [7:0] EXT2_CLR     = 8'h3f;
  localparam logic [7:0] AUX_TX_CLR   = 8'h44;
  localparam logic [7:0] AUX_RX_CLR   = 8'h33;
  localparam logic [7:0] AUX_WR_MASK  = 8'hfe;
  localparam logic [7:0] EXT1_WR_MASK = 8'hb1;
  localparam logic [7:0] EXT2_WR_MASK = 8'hb0;
  localparam logic [2:0] MODE_UART    = 3'h0;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [15:0] DIV_RESET   = 16'h0000;

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PRE_13    = 2'b00,
    PRE_1P625 = 2'b01,
    PRE_RSVD  = 2'b10,
    PRE_1     = 2'b11
  } ubd_prescaler_select_t;

  localparam logic [3:0] PRE13_LAST = 4'hc;
  localparam logic [3:0] FRAC_STEP  = 4'h8;
  localparam logic [3:0] FRAC_MOD   = 4'hd;
  localparam logic [3:0] BIT_LAST   = 4'hf;

endpackage : ubd_pkg

// >>> ubd_prescaler.sv
module ubd_prescaler
  import ubd_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       in_pulse,
  input  wire ubd_prescaler_select_t sel,
  output logic            out_pulse
);

  logic [3:0] acc_reg;
  logic [4:0] frac_sum;

  // 1.625 = 13/8: eight outputs for every thirteen inputs
  assign frac_sum = {1'b0, acc_reg} + {1'b0, FRAC_STEP};

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_reg   <= 4'h0;
      out_pulse <= 1'b0;
    end else begin
      out_pulse <= 1'b0;
      if (in_pulse) begin
        unique case (sel)
          PRE_1P625: begin
            if (frac_sum >= {1'b0, FRAC_MOD}) begin
              acc_reg   <= 4'(frac_sum - {1'b0, FRAC_MOD});
              out_pulse <= 1'b1;
            end else begin
              acc_reg <= frac_sum[3:0];
            end
          end
          PRE_1: begin
            acc_reg   <= 4'h0;
            out_pulse <= 1'b1;
          end
          // reserved code behaves as divide by 13
          PRE_13, PRE_RSVD: begin
            if (acc_reg >= PRE13_LAST) begin
              acc_reg   <= 4'h0;
              out_pulse <= 1'b1;
            end else begin
              acc_reg <= acc_reg + 4'h1;
            end
          end
        endcase
      end
    end
  end

endmodule // ubd_prescaler

// >>> ubd_baud_counter.sv
module ubd_baud_counter
  import ubd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        step,
  input  wire logic        load,
  input  wire logic [15:0] divisor,
  output logic             tick
);

  logic [15:0] count_reg;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= DIV_RESET;
      tick      <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (load) begin
        count_reg <= divisor;
      end else if (step) begin
        // zero is forbidden; it is treated like one
        if (count_reg <= 16'h0001) begin
          count_reg <= divisor;
          tick      <= 1'b1;
        end else begin
          count_reg <= count_reg - 16'h0001;
        end
      end
    end
  end

endmodule // ubd_baud_counter

// >>> ubd_divisor_fallback.sv
module ubd_divisor_fallback
  import ubd_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  input  ubd_pkg::ubd_bus_req_t bus,
  output logic [7:0]         rd_data,
  input  wire logic          clk24_pin,
  input  wire logic          rx_timeout_event,
  input  wire logic          rx_fifo_read,
  input  wire logic          tx_soft_reset,
  input  wire logic          rx_soft_reset,
  input  wire logic [4:0]    tx_fifo_fill_level,
  input  wire logic [4:0]    rx_fifo_fill_level,
  output logic [7:0]         modem_mode_control,
  output logic [7:0]         extended_control_one,
  output logic [7:0]         extended_control_two,
  output logic [7:0]         line_control,
  output logic               fallback_event,
  output logic               sixteen_x_baud_tick,
  output logic               bit_rate_tick
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]  mcr_reg;
  logic [7:0]  ext1_reg;
  logic [7:0]  ext2_reg;
  logic [7:0]  lcr_reg;
  logic [7:0]  scratch_reg;
  logic [7:0]  aux_reg;
  logic [7:0]  aux_next;
  logic [7:0]  lock_lo_reg;
  logic [7:0]  lock_hi_reg;
  logic [15:0] divisor_reg;
  logic        div_load_reg;
  logic [7:0]  rd_next;
  logic [3:0]  bit_cnt_reg;
  logic        sync1_reg;
  logic        sync2_reg;
  logic        sync3_reg;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  ubd_bank_t bank;
  logic      access;
  logic      ext_mode;
  logic      locked;
  logic      div_off;
  logic      legacy_hit;
  logic      redirect;
  logic      fallback;
  logic      bank2_div;
  logic      div_write;
  logic      pre_pulse;
  logic      tick16;
  logic      edge24;

  always_comb begin
    if (!lcr_reg[BANK_SELECT_ENABLE_BIT]) begin
      bank = BANK0;
    end else if (lcr_reg == BANK2_CODE) begin
      bank = BANK2;
    end else if (lcr_reg == BANK3_CODE) begin
      bank = BANK3;
    end else begin
      bank = BANK1;
    end
  end

  assign access     = bus.rd | bus.wr;
  assign ext_mode   = ext1_reg[EXT_SEL_BIT];
  assign locked     = ext2_reg[LOCK_BIT];
  assign div_off    = (bus.addr == OFF_DIV_LO) | (bus.addr == OFF_DIV_HI);
  assign legacy_hit = access & (bank == BANK1) & div_off;
  // locking only holds while in non-extended mode
  assign redirect   = legacy_hit & ~ext_mode & locked;
  assign fallback   = legacy_hit & ~redirect;
  assign bank2_div  = (bank == BANK2) & div_off;
  assign div_write  = bus.wr & (bank2_div | fallback);

  // ---------------------------------------------------------------
  // 24 MHz pin: two flops, then edge detect on the second
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= clk24_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign edge24 = sync2_reg & ~sync3_reg;

  // ---------------------------------------------------------------
  // line control, written from every bank
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lcr_reg <= REG_RESET;
    end else if (bus.wr && bus.addr == OFF_LCR) begin
      lcr_reg <= bus.wdata;
    end
  end

  // ---------------------------------------------------------------
  // mode control byte
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mcr_reg <= REG_RESET;
    end else if (fallback && ext_mode) begin
      mcr_reg <= mcr_reg & ~MCR_CLR_EXT;
    end else if (bus.wr && bank == BANK0 && bus.addr == OFF_MCR) begin
      mcr_reg <= bus.wdata;
    end
  end

  // ---------------------------------------------------------------
  // extended control one
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext1_reg <= REG_RESET;
    end else if (fallback) begin
      if (ext_mode) begin
        ext1_reg <= ext1_reg & ~EXT1_CLR_EXT;
      end else begin
        ext1_reg <= ext1_reg & ~EXT1_CLR_NE;
      end
    end else if (bus.wr && bank == BANK2 && bus.addr == OFF_EXT1) begin
      ext1_reg <= bus.wdata & EXT1_WR_MASK;
    end
  end

  // ---------------------------------------------------------------
  // extended control two: prescaler and lock
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext2_reg <= REG_RESET;
    end else if (fallback) begin
      ext2_reg <= ext2_reg & ~EXT2_CLR;
    end else if (bus.wr && bank == BANK2 && bus.addr == OFF_EXT2) begin
      ext2_reg <= bus.wdata & EXT2_WR_MASK;
    end
  end

  // ---------------------------------------------------------------
  // divisor and the locked overlay bytes
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      divisor_reg <= DIV_RESET;
    end else if (div_write) begin
      if (bus.addr == OFF_DIV_LO) begin
        divisor_reg[7:0] <= bus.wdata;
      end else begin
        divisor_reg[15:8] <= bus.wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_lo_reg <= REG_RESET;
      lock_hi_reg <= REG_RESET;
    end else if (redirect && bus.wr) begin
      if (bus.addr == OFF_DIV_LO) begin
        lock_lo_reg <= bus.wdata;
      end else begin
        lock_hi_reg <= bus.wdata;
      end
    end
  end

  // counter reload follows the byte write by one cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_load_reg <= 1'b0;
    end else begin
      div_load_reg <= div_write;
    end
  end

  // ---------------------------------------------------------------
  // scratch and aux byte at one address
  // ---------------------------------------------------------------
  logic aux_hit;

  assign aux_hit = (bank == BANK0) & (bus.addr == OFF_AUX);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scratch_reg <= REG_RESET;
    end else if (bus.wr && aux_hit && !ext_mode) begin
      scratch_reg <= bus.wdata;
    end
  end

  always_comb begin
    aux_next = aux_reg;
    // in the plain uart mode the upper bits are reserved zeros
    if (bus.wr && aux_hit && ext_mode &&
        mcr_reg[MODE_LO +: 3] != MODE_UART) begin
      aux_next = (aux_reg & ~AUX_WR_MASK) | (bus.wdata & AUX_WR_MASK);
    end
    if (rx_fifo_read) begin
      aux_next[RXTO_BIT] = 1'b0;
    end
    if (tx_soft_reset) begin
      aux_next = aux_next & ~AUX_TX_CLR;
    end
    if (rx_soft_reset) begin
      aux_next = aux_next & ~AUX_RX_CLR;
    end
    // a timeout in the clearing cycle still lands
    if (rx_timeout_event) begin
      aux_next[RXTO_BIT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aux_reg <= REG_RESET;
    end else begin
      aux_reg <= aux_next;
    end
  end

  // ---------------------------------------------------------------
  // read path, data valid the cycle after the strobe only
  // ---------------------------------------------------------------
  always_comb begin
    rd_next = REG_RESET;
    if (bus.rd) begin
      unique case (bank)
        BANK0: begin
          if (bus.addr == OFF_LCR) begin
            rd_next = lcr_reg;
          end else if (bus.addr == OFF_MCR) begin
            rd_next = mcr_reg;
          end else if (bus.addr == OFF_AUX && !ext_mode) begin
            rd_next = scratch_reg;
          end else if (bus.addr == OFF_AUX) begin
            rd_next = aux_reg;
            // plain uart mode: stale upper bits read as reserved zeros
            if (mcr_reg[MODE_LO +: 3] == MODE_UART) begin
              rd_next = aux_reg & ~AUX_WR_MASK;
            end
          end
        end
        BANK1: begin
          if (bus.addr == OFF_DIV_LO) begin
            rd_next = redirect ? lock_lo_reg : divisor_reg[7:0];
          end else if (bus.addr == OFF_DIV_HI) begin
            rd_next = redirect ? lock_hi_reg : divisor_reg[15:8];
          end else if (bus.addr == OFF_LCR) begin
            rd_next = lcr_reg;
          end
        end
        BANK2: begin
          unique case (bus.addr)
            OFF_DIV_LO: rd_next = divisor_reg[7:0];
            OFF_DIV_HI: rd_next = divisor_reg[15:8];
            OFF_EXT1:   rd_next = ext1_reg;
            OFF_LCR:    rd_next = lcr_reg;
            OFF_EXT2:   rd_next = ext2_reg;
            OFF_TXLV:   rd_next = {3'h0, tx_fifo_fill_level};
            OFF_RXLV:   rd_next = {3'h0, rx_fifo_fill_level};
            default:    rd_next = REG_RESET;
          endcase
        end
        BANK3: begin
          if (bus.addr == OFF_LCR) begin
            rd_next = lcr_reg;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= REG_RESET;
    end else begin
      rd_data <= rd_next;
    end
  end

  // ---------------------------------------------------------------
  // baud generation
  // ---------------------------------------------------------------
  ubd_prescaler u_prescaler (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_pulse  (edge24),
    .sel       (ubd_prescaler_select_t'(ext2_reg[PRESCALER_SELECT_LO +: 2])),
    .out_pulse (pre_pulse)
  );

  ubd_baud_counter u_baud_counter (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .step    (pre_pulse),
    .load    (div_load_reg),
    .divisor (divisor_reg),
    .tick    (tick16)
  );

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_reg   <= 4'h0;
      bit_rate_tick <= 1'b0;
    end else begin
      bit_rate_tick <= 1'b0;
      if (div_load_reg) begin
        bit_cnt_reg <= 4'h0;
      end else if (tick16) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (bit_cnt_reg == BIT_LAST) begin
          bit_rate_tick <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sixteen_x_baud_tick <= 1'b0;
      fallback_event      <= 1'b0;
    end else begin
      sixteen_x_baud_tick <= tick16;
      fallback_event      <= fallback;
    end
  end

  // ---------------------------------------------------------------
  // control bytes out to the rest of the uart
  // ---------------------------------------------------------------
  assign modem_mode_control   = mcr_reg;
  assign extended_control_one = ext1_reg;
  assign extended_control_two = ext2_reg;
  assign line_control         = lcr_reg;

endmodule // ubd_divisor_fallback

// >>> ubd_host_model.sv
module ubd_host_model
  import ubd_pkg::*;
(
  input  wire logic             ref_clk,
  output ubd_pkg::ubd_bus_req_t bus,
  input  wire logic [7:0]       rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus = '0;

  // one strobe cycle, results looked at on the falling edge after it
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    bus <= '0;
    @(negedge ref_clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    bus <= '0;
    @(negedge ref_clk);
    v = rd_data;
  endtask
endmodule // ubd_host_model

// >>> ubd_divisor_fallback_asserts.sv
module ubd_divisor_fallback_asserts
  import ubd_pkg::*;
(
  input wire logic             ref_clk,
  input wire logic             reset_n,
  input ubd_pkg::ubd_bus_req_t bus,
  input wire logic [7:0]       rd_data,
  input wire logic [4:0]       tx_fifo_fill_level,
  input wire logic [7:0]       modem_mode_control,
  input wire logic [7:0]       extended_control_one,
  input wire logic [7:0]       extended_control_two,
  input wire logic [7:0]       line_control,
  input wire logic             fallback_event,
  input wire logic             sixteen_x_baud_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  logic acc, bank1, bank2, ext, lock_ne, legacy, cause_reg;
  assign acc = bus.wr || bus.rd;
  assign bank1 = line_control[7] && line_control != BANK2_CODE
                 && line_control != BANK3_CODE;
  assign bank2 = line_control == BANK2_CODE;
  assign ext = extended_control_one[EXT_SEL_BIT];
  assign lock_ne = !ext && extended_control_two[LOCK_BIT];
  assign legacy = acc && bank1 && bus.addr <= OFF_DIV_HI;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) cause_reg <= 1'b0;
    else cause_reg <= legacy && !lock_ne;
  end

  AST_FB_PULSE: assert property (legacy && !lock_ne
    |=> fallback_event)
    else $error("fallback pulse missing");
  AST_FB_CAUSE: assert property (fallback_event |-> cause_reg)
    else $error("fallback without legacy divisor access");
  AST_LOCKED: assert property (legacy && lock_ne |=> !fallback_event
    && $stable(extended_control_one) && $stable(extended_control_two)
    && $stable(modem_mode_control))
    else $error("locked access had side effects");
  AST_FB_EXT: assert property (legacy && ext |=>
    (modem_mode_control & 8'hfc) == 8'h00
    && (extended_control_one & EXT1_CLR_EXT) == 8'h00
    && (extended_control_two & EXT2_CLR) == 8'h00)
    else $error("extended fallback clear wrong");
  AST_FB_NE: assert property (legacy && !ext && !lock_ne |=>
    (extended_control_one & EXT1_CLR_NE) == 8'h00
    && (extended_control_two & EXT2_CLR) == 8'h00
    && $stable(modem_mode_control))
    else $error("non-extended fallback clear wrong");
  AST_B2_NOFB: assert property (acc && bank2 && bus.addr <= OFF_DIV_HI
    |=> !fallback_event && $stable(extended_control_one))
    else $error("bank 2 divisor access changed mode");
  AST_LINE_WR: assert property (bus.wr && bus.addr == 3'h3
    |=> line_control == $past(bus.wdata))
    else $error("line control write lost");
  AST_B1_RSVD: assert property (bus.rd && bank1
    && (bus.addr == 3'h2 || bus.addr >= 3'h4) |=> rd_data == 8'h00)
    else $error("reserved bank 1 read not zero");
  AST_TX_LEVEL: assert property (bus.rd && bank2
    && bus.addr == OFF_TXLV
    |=> rd_data == {3'h0, $past(tx_fifo_fill_level)})
    else $error("tx level read wrong");
  AST_TICK_GAP: assert property (sixteen_x_baud_tick
    |=> !sixteen_x_baud_tick [*3])
    else $error("baud tick too close");

  COV_FB_EXT: cover property (legacy && ext);
  COV_LOCKED: cover property (legacy && lock_ne);
  COV_TICK: cover property (sixteen_x_baud_tick);
endmodule // ubd_divisor_fallback_asserts

bind ubd_divisor_fallback ubd_divisor_fallback_asserts u_asserts (
  .ref_clk(ref_clk), .reset_n(reset_n), .bus(bus), .rd_data(rd_data),
  .tx_fifo_fill_level(tx_fifo_fill_level),
  .modem_mode_control(modem_mode_control),
  .extended_control_one(extended_control_one),
  .extended_control_two(extended_control_two),
  .line_control(line_control), .fallback_event(fallback_event),
  .sixteen_x_baud_tick(sixteen_x_baud_tick));

// >>> test_ubd_divisor_fallback.sv
module test_ubd_divisor_fallback;
  import ubd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic         ref_clk, reset_n, clk24_pin, fb_o, tick16, tickb;
  logic [3:0]   ev;
  logic [4:0]   txl, rxl;
  logic [7:0]   rd_data, mode_o, e1_o, e2_o, line_o;
  ubd_bus_req_t bus;
  int           n_errors, cmp_count, cyc, e24, last24, per, ntk, tcnt, bper;
  int           lc, mm, x1, x2, dv, scratch, aux, ovl[2];

  ubd_divisor_fallback DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .bus(bus), .rd_data(rd_data),
    .clk24_pin(clk24_pin), .rx_timeout_event(ev[0]),
    .rx_fifo_read(ev[1]), .tx_soft_reset(ev[2]), .rx_soft_reset(ev[3]),
    .tx_fifo_fill_level(txl), .rx_fifo_fill_level(rxl),
    .modem_mode_control(mode_o), .extended_control_one(e1_o),
    .extended_control_two(e2_o), .line_control(line_o),
    .fallback_event(fb_o), .sixteen_x_baud_tick(tick16),
    .bit_rate_tick(tickb));
  ubd_host_model host (.ref_clk(ref_clk), .bus(bus), .rd_data(rd_data));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // 24 MHz source, free running and unrelated in phase
  initial begin
    clk24_pin = 1'b0;
    forever #20.833 clk24_pin = ~clk24_pin;
  end
  always @(posedge clk24_pin) e24++;

  always @(posedge ref_clk) begin
    cyc++;
    tcnt += int'(tick16);
    if (tick16) begin
      per = e24 - last24;
      last24 = e24;
      ntk++;
    end
    if (tickb) begin
      bper = tcnt;
      tcnt = 0;
    end
    if (cyc == 60000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input int exp);
    cmp_count++;
    if (seen !== 16'(exp)) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen,
               16'(exp));
    end
  endtask

  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  function automatic int bk();
    if (!lc[7]) return 0;
    if (lc == 8'he0) return 2;
    if (lc == 8'he4) return 3;
    return 1;
  endfunction

  function automatic void fbk();
    if (x1[0]) mm &= 8'h03;
    x1 &= x1[0] ? 8'h5e : 8'h5f;
    x2 &= 8'hc0;
  endfunction

  task automatic post(input int f);
    check(fb_o, f);
    check(mode_o, mm);
    check(e1_o, x1);
    check(e2_o, x2);
    check(line_o, lc);
  endtask

  task automatic mwr(input int a, input int d);
    int b;
    int f;
    b = bk();
    f = 0;
    host.wr(3'(a), 8'(d));
    if (a == 3) lc = d;
    else if (b == 0 && a == 4) mm = d;
    else if (b == 0 && a == 7 && !x1[0]) scratch = d;
    else if (b == 0 && a == 7 && mm[7:5] != 0) aux = aux & 1 | d & 8'hfe;
    else if (b == 1 && a < 2 && !x1[0] && x2[7]) ovl[a] = d;
    else if (b == 1 && a < 2) begin
      fbk();
      f = 1;
    end
    else if (b == 2 && a == 2) x1 = d & 8'hb1;
    else if (b == 2 && a == 4) x2 = d & 8'hb0;
    if ((b == 2 || f == 1) && a < 2)
      dv = a == 1 ? dv & 8'hff | d << 8 : dv & 16'hff00 | d;
    post(f);
  endtask

  task automatic mrd(input int a);
    logic [7:0] v;
    int b;
    int e;
    int f;
    b = bk();
    e = 0;
    f = 0;
    host.rd(3'(a), v);
    if (a == 3) e = lc;
    else if (b == 0 && a == 4) e = mm;
    else if (b == 0 && a == 7) e = !x1[0] ? scratch : mm[7:5] ? aux : aux & 1;
    else if (b == 1 && a < 2 && !x1[0] && x2[7]) e = ovl[a];
    else if (b == 1 && a < 2) begin
      e = dv >> 8 * a & 8'hff;
      fbk();
      f = 1;
    end
    else if (b == 2 && a < 2) e = dv >> 8 * a & 8'hff;
    else if (b == 2 && a == 2) e = x1;
    else if (b == 2 && a == 4) e = x2;
    else if (b == 2 && a == 6) e = txl;
    else if (b == 2 && a == 7) e = rxl;
    check(v, e);
    post(f);
  endtask

  task automatic evp(input int i);
    @(posedge ref_clk);
    ev <= 4'h1 << i;
    @(posedge ref_clk);
    ev <= 4'h0;
    @(negedge ref_clk);
    if (i == 0) aux |= 1;
    else if (i == 1) aux &= ~1;
    else aux &= i == 2 ? ~8'h44 : ~8'h33;
    mrd(7);
  endtask

  task automatic rst();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    {lc, mm, x1, x2, dv, scratch, aux, ovl[0], ovl[1]} = '0;
    repeat (2) @(posedge ref_clk);
  endtask

  // 16x tick spacing in 24 MHz edges for one prescaler code
  task automatic baud(input int c, input int d);
    int k;
    mwr(4, c << 4);
    mwr(0, d);
    mwr(1, 0);
    k = ntk;
    for (int i = 0; i < 5000 && ntk < k + 3; i++) @(negedge ref_clk);
    check(16'(per), c == 1 ? d * 13 / 8
          : c == 3 ? d : d * 13);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    ev = 4'h0;
    void'($urandom(75458));
    txl = 5'($urandom);
    rxl = 5'($urandom);
    rst();
    mwr(7, $urandom & 8'hff);
    for (int a = 0; a < 8; a++) mrd(a);
    mwr(3, 8'h80);
    mwr(0, 1 + $urandom % 255);
    mwr(1, $urandom & 8'hff);
    for (int a = 0; a < 8; a++) mrd(a);
    mwr(3, 8'he0);
    mwr(2, 8'hff);
    mwr(4, 8'h3f);
    mwr(5, 8'hff);
    for (int a = 0; a < 8; a++) mrd(a);
    mwr(3, 8'he4);
    for (int a = 0; a < 8; a++) mrd(a);
    mwr(3, 8'h00);
    mwr(4, 8'hff);
    mwr(7, 8'hff);
    mrd(7);
    for (int i = 0; i < 4; i++) evp(i);
    evp(0);
    evp(3);
    mwr(4, 8'h00);
    evp(0);
    rst();
    mwr(3, 8'he0);
    mwr(2, 8'h01);
    mwr(4, 8'h3f);
    mwr(3, 8'h00);
    mrd(7);
    mwr(4, 8'hff);
    mwr(3, 8'h80);
    mrd(1);
    mwr(3, 8'he0);
    mwr(2, 8'hb0);
    mwr(4, 8'h30);
    mwr(3, 8'h80);
    mwr(0, 8'h05);
    mwr(3, 8'he0);
    mwr(4, 8'hb0);
    mwr(3, 8'h80);
    mwr(0, 8'h77);
    mwr(1, 8'h66);
    mrd(0);
    mrd(1);
    mwr(3, 8'he0);
    mrd(0);
    mrd(1);
    for (int c = 0; c < 4; c++) baud(c, 8);
    baud(3, 1);
    for (int i = 0, k = ntk; i < 3000 && ntk < k + 40; i++) @(negedge ref_clk);
    check(16'(bper), 16);
    finish_test();
  end
endmodule // test_ubd_divisor_fallback
